// ==== hdl/crb_pkg.sv ====
// package: register map, field positions and timing counts of the capture/reload baud timer
package crb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'hC9;
  localparam logic [7:0] IDX_CAPTURE_RELOAD_LOW = 8'hE4;
  localparam logic [7:0] IDX_CAPTURE_RELOAD_HIGH = 8'hE5;
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hF0;
  localparam logic [7:0] IDX_COUNT_READBACK = 8'hF4;
  // timer_control fields
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_EXTERNAL_EDGE_FLAG = 6;
  localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
  localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
  localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_COUNTER_SELECT = 1;
  localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
  // clock_control field
  localparam int BIT_CLOCK_DIVIDE_SELECT = 0;
  // reset values
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [15:0] RST_CAPTURE_RELOAD = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic RST_CLOCK_DIVIDE_SELECT = 1'b0;
  // timebase divisors
  localparam int SLOW_DIVIDE = 12;
  localparam int BAUD_DIVIDE = 2;
  localparam logic [3:0] SLOW_LAST = 4'(SLOW_DIVIDE - 1);
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  typedef enum {
    CRB_OFF,
    CRB_CAPTURE,
    CRB_RELOAD,
    CRB_BAUD
  } crb_mode_type;
endpackage : crb_pkg

// ==== hdl/crb_timer.sv ====
// capture/reload/baud 16-bit timer with an AHB-Lite register slave
//
// What this block does
// - capture-mode trigger fall copies count, sets flag
// - count system_clock, system_clock/12, or count-pin falls
// - rollover in capture/reload sets overflow flag
// - capture mode needs select and run; enable gates
// - reload mode overflow loads capture pair
// - select zero means reload; run starts counting
// - reload-mode trigger fall reloads and sets flag
// - baud overflow reloads, no flag, feeds UART
// - either clock select forces baud mode
// - baud timer timebase is system_clock over two
// - baud counter mode counts the count pin
// - baud trigger fall only sets external flag
// - each direction picks timer1 or this timer
// - flags stay set until software clears them
// - run bit zero stops counter in every mode
// - capture bytes take count, serve as reload
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module crb_timer
  import crb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic count_pin_i,
  input wire logic trigger_pin_i,
  input wire logic timer1_overflow_i,
  output logic rx_shift_tick_o,
  output logic tx_shift_tick_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] cap;
    logic [15:0] count;
    logic ckdiv;
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_prev;
    logic trg_s1;
    logic trg_s2;
    logic trg_prev;
    logic [3:0] pre;
    logic half;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic baud_tick;
  } crb_state_type;

  crb_state_type st;
  crb_state_type next_st;
  crb_mode_type mode;
  logic run;
  logic baud;
  logic ext_en;
  logic cnt_fall;
  logic trg_fall;
  logic tick;
  logic ovf;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic wr_ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and timebase
  assign run = st.ctrl[BIT_RUN_CONTROL];
  assign baud = st.ctrl[BIT_RECEIVE_CLOCK_SELECT] | st.ctrl[BIT_TRANSMIT_CLOCK_SELECT];
  assign ext_en = st.ctrl[BIT_EXTERNAL_TRIGGER_ENABLE];
  assign cnt_fall = st.cnt_prev & ~st.cnt_s2;
  assign trg_fall = st.trg_prev & ~st.trg_s2;
  assign addr_ok = (haddr_i[31:10] == 22'h000000);
  assign addr_idx = haddr_i[9:2];
  assign wr_ctrl = st.wr_pend & (st.wr_idx == IDX_TIMER_CONTROL);

  always_comb begin
    if (!run) begin
      mode = CRB_OFF;
    end else if (baud) begin
      mode = CRB_BAUD;
    end else if (st.ctrl[BIT_CAPTURE_RELOAD_SELECT]) begin
      mode = CRB_CAPTURE;
    end else begin
      mode = CRB_RELOAD;
    end
  end

  always_comb begin
    if (st.ctrl[BIT_COUNTER_SELECT]) begin
      tick = cnt_fall;
    end else if (baud) begin
      tick = st.half;
    end else if (st.ckdiv) begin
      tick = 1'b1;
    end else begin
      tick = (st.pre == SLOW_LAST);
    end
  end

  assign ovf = (mode != CRB_OFF) & tick & (st.count == COUNT_ALL_ONES);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.cnt_s1 = count_pin_i;
    next_st.cnt_s2 = st.cnt_s1;
    next_st.cnt_prev = st.cnt_s2;
    next_st.trg_s1 = trigger_pin_i;
    next_st.trg_s2 = st.trg_s1;
    next_st.trg_prev = st.trg_s2;
    next_st.pre = (st.pre == SLOW_LAST) ? 4'h0 : st.pre + 4'h1;
    next_st.half = ~st.half;
    next_st.baud_tick = 1'b0;

    // software write from the data phase; hardware sets below win over it
    if (st.wr_pend) begin
      case (st.wr_idx)
        IDX_TIMER_CONTROL: begin
          next_st.ctrl = hwdata_i[7:0];
        end
        IDX_CAPTURE_RELOAD_LOW: begin
          next_st.cap[7:0] = hwdata_i[7:0];
        end
        IDX_CAPTURE_RELOAD_HIGH: begin
          next_st.cap[15:8] = hwdata_i[7:0];
        end
        IDX_CLOCK_CONTROL: begin
          next_st.ckdiv = hwdata_i[BIT_CLOCK_DIVIDE_SELECT];
        end
        default: begin
          next_st.ctrl = next_st.ctrl;
        end
      endcase
    end

    // counting
    if (mode != CRB_OFF && tick) begin
      if (ovf) begin
        if (mode == CRB_CAPTURE) begin
          next_st.count = RST_COUNT;
        end else begin
          next_st.count = st.cap;
        end
        if (mode == CRB_BAUD) begin
          next_st.baud_tick = 1'b1;
        end else begin
          next_st.ctrl[BIT_OVERFLOW_FLAG] = 1'b1;
        end
      end else begin
        next_st.count = st.count + 16'h0001;
      end
    end

    // trigger pin
    // a pin reload overrides a count step in the same cycle
    if (mode != CRB_OFF && ext_en && trg_fall) begin
      next_st.ctrl[BIT_EXTERNAL_EDGE_FLAG] = 1'b1;
      case (mode)
        CRB_CAPTURE: begin
          next_st.cap = st.count;
        end
        CRB_RELOAD: begin
          next_st.count = st.cap;
        end
        default: begin
          next_st.cap = next_st.cap;
        end
      endcase
    end

    // address phase
    next_st.wr_pend = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      next_st.wr_pend = hwrite_i & addr_ok;
      next_st.wr_idx = addr_idx;
      if (!hwrite_i) begin
        next_st.rdata = 32'h00000000;
        if (addr_ok) begin
          case (addr_idx)
            IDX_TIMER_CONTROL: begin
              next_st.rdata[7:0] = next_st.ctrl;
            end
            IDX_CAPTURE_RELOAD_LOW: begin
              next_st.rdata[7:0] = next_st.cap[7:0];
            end
            IDX_CAPTURE_RELOAD_HIGH: begin
              next_st.rdata[7:0] = next_st.cap[15:8];
            end
            IDX_CLOCK_CONTROL: begin
              next_st.rdata[BIT_CLOCK_DIVIDE_SELECT] = next_st.ckdiv;
            end
            IDX_COUNT_READBACK: begin
              next_st.rdata[15:0] = next_st.count;
            end
            default: begin
              next_st.rdata = 32'h00000000;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.ctrl <= RST_TIMER_CONTROL;
      st.cap <= RST_CAPTURE_RELOAD;
      st.count <= RST_COUNT;
      st.ckdiv <= RST_CLOCK_DIVIDE_SELECT;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata_o = st.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign rx_shift_tick_o = st.ctrl[BIT_RECEIVE_CLOCK_SELECT] ? st.baud_tick
                                                             : timer1_overflow_i;
  assign tx_shift_tick_o = st.ctrl[BIT_TRANSMIT_CLOCK_SELECT] ? st.baud_tick
                                                              : timer1_overflow_i;
  assign irq_o = st.ctrl[BIT_OVERFLOW_FLAG] | st.ctrl[BIT_EXTERNAL_EDGE_FLAG];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking crb_cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence trig_in_capture_s;
    (mode == CRB_CAPTURE) && ext_en && trg_fall;
  endsequence

  sequence reload_overflow_s;
    (mode == CRB_RELOAD) && ovf && !(ext_en && trg_fall);
  endsequence

  sequence baud_overflow_s;
    (mode == CRB_BAUD) && ovf && !wr_ctrl && !st.ctrl[BIT_OVERFLOW_FLAG];
  endsequence

  capture_copy_a: assert property (trig_in_capture_s |=>
    (st.cap == $past(st.count)) && st.ctrl[BIT_EXTERNAL_EDGE_FLAG])
    else $error("capture did not copy the count");
  overflow_flag_a: assert property (((mode == CRB_CAPTURE) || (mode == CRB_RELOAD))
    && ovf |=> st.ctrl[BIT_OVERFLOW_FLAG] ##0 irq_o)
    else $error("overflow flag not set on rollover");
  reload_value_a: assert property (reload_overflow_s |=> st.count == $past(st.cap))
    else $error("reload value not loaded on overflow");
  baud_no_flag_a: assert property (baud_overflow_s |=>
    !st.ctrl[BIT_OVERFLOW_FLAG] && st.baud_tick)
    else $error("baud overflow set the flag or gave no tick");
  stopped_count_a: assert property (!run |=> $stable(st.count))
    else $error("counter moved while stopped");
  flag_hold_a: assert property (st.ctrl[BIT_EXTERNAL_EDGE_FLAG] && !wr_ctrl
    |=> st.ctrl[BIT_EXTERNAL_EDGE_FLAG])
    else $error("external flag cleared without software");
  baud_trigger_a: assert property ((mode == CRB_BAUD) && ext_en && trg_fall
    && !st.wr_pend |=> st.ctrl[BIT_EXTERNAL_EDGE_FLAG] && $stable(st.cap))
    else $error("baud trigger handled wrongly");
  slow_tick_a: assert property (run && !baud && !st.ctrl[BIT_COUNTER_SELECT]
    && !st.ckdiv && (st.pre != SLOW_LAST) && !(ext_en && trg_fall) |=> $stable(st.count))
    else $error("divided timebase stepped early");
  pin_fall_a: assert property ($fell(st.cnt_s2) |-> cnt_fall ##1 !cnt_fall)
    else $error("count pin fall not seen for one cycle");

  sequence trig_in_reload_s;
    (mode == CRB_RELOAD) && ext_en && trg_fall;
  endsequence

  sequence baud_pin_idle_s;
    (mode == CRB_BAUD) && st.ctrl[BIT_COUNTER_SELECT] && !cnt_fall;
  endsequence

  // trigger pin checks
  trigger_reload_a: assert property (trig_in_reload_s |=>
    (st.count == $past(st.cap)) && st.ctrl[BIT_EXTERNAL_EDGE_FLAG])
    else $error("trigger did not reload the count");
  trigger_off_a: assert property ((mode != CRB_OFF) && !ext_en && trg_fall
    && !st.wr_pend && !st.ctrl[BIT_EXTERNAL_EDGE_FLAG]
    |=> !st.ctrl[BIT_EXTERNAL_EDGE_FLAG] && $stable(st.cap))
    else $error("disabled trigger was acted on");
  off_trigger_a: assert property ((mode == CRB_OFF) && trg_fall && !st.wr_pend
    |=> $stable(st.ctrl) && $stable(st.cap))
    else $error("trigger acted while the timer was off");
  capture_hold_a: assert property (trig_in_capture_s ##0 !tick |=> $stable(st.count))
    else $error("capture disturbed the count");

  // counting checks
  fast_step_a: assert property (run && !baud && !st.ctrl[BIT_COUNTER_SELECT]
    && st.ckdiv && (st.count != COUNT_ALL_ONES) && !(ext_en && trg_fall)
    |=> st.count == $past(st.count) + 16'h0001)
    else $error("undivided timebase missed a step");
  pin_step_a: assert property (run && !baud && st.ctrl[BIT_COUNTER_SELECT] && cnt_fall
    && (st.count != COUNT_ALL_ONES) && !(ext_en && trg_fall)
    |=> st.count == $past(st.count) + 16'h0001)
    else $error("count pin fall did not step the counter");
  capture_wrap_a: assert property ((mode == CRB_CAPTURE) && ovf
    |=> st.count == RST_COUNT)
    else $error("capture overflow did not wrap to zero");
  baud_reload_a: assert property ((mode == CRB_BAUD) && ovf
    |=> st.count == $past(st.cap))
    else $error("baud overflow did not reload");
  baud_half_a: assert property ((mode == CRB_BAUD) && !st.ctrl[BIT_COUNTER_SELECT]
    && !st.half |=> $stable(st.count))
    else $error("baud timebase stepped on a held half");
  baud_pin_a: assert property (baud_pin_idle_s |=> $stable(st.count))
    else $error("pin-clocked baud counter moved without a pin fall");
  baud_pin_step_a: assert property ((mode == CRB_BAUD) && st.ctrl[BIT_COUNTER_SELECT]
    && cnt_fall && (st.count != COUNT_ALL_ONES) |=> st.count == $past(st.count) + 16'h0001)
    else $error("pin-clocked baud counter missed a step");

  // flags and shift ticks
  overflow_hold_a: assert property (st.ctrl[BIT_OVERFLOW_FLAG] && !wr_ctrl
    |=> st.ctrl[BIT_OVERFLOW_FLAG])
    else $error("overflow flag cleared without software");
  rx_baud_tick_a: assert property ((mode == CRB_BAUD) && ovf && !wr_ctrl
    && st.ctrl[BIT_RECEIVE_CLOCK_SELECT] |=> rx_shift_tick_o)
    else $error("receive shift tick missing after baud overflow");
  tx_timer1_a: assert property (!st.ctrl[BIT_TRANSMIT_CLOCK_SELECT]
    |-> tx_shift_tick_o == timer1_overflow_i)
    else $error("transmit shift tick not taken from timer 1");

endmodule : crb_timer

// ==== sim/capture_reload_baud_timer_test.sv ====
// self-checking bench of the capture/reload baud timer
`timescale 1ns/1ps
module capture_reload_baud_timer_test;
  import crb_pkg::*;
  logic clk = 0, rst = 1, hsel = 1, hwrite = 0, cpin = 1, tpin = 1;
  logic hrdy, hresp, rxt, txt, t1o, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, p;
  logic [1:0] htrans = 0;
  int rxn, txn, r0, t0, num_errors = 0, n_tests = 0;
  always #50 clk = ~clk;
  crb_timer u_dut (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .count_pin_i(cpin), .trigger_pin_i(tpin), .timer1_overflow_i(t1o),
    .rx_shift_tick_o(rxt), .tx_shift_tick_o(txt), .irq_o(irq));
  crb_uart_model u_uart (.clk_i(clk), .rst_i(rst), .rx_tick_i(rxt), .tx_tick_i(txt),
    .t1_ovf_o(t1o), .rx_cnt_o(rxn), .tx_cnt_o(txn));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic rdy();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    rdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    rdy();
    rd = hrdata;
  endtask : bus
  task automatic fall(input bit trig);
    if (trig) tpin <= 0;
    else cpin <= 0;
    repeat (4) @(posedge clk);
    if (trig) tpin <= 1;
    else cpin <= 1;
    repeat (6) @(posedge clk);
  endtask : fall
  ////////////////////////////////////////
  task automatic s_reset();
    logic [7:0] ix [6] = '{IDX_TIMER_CONTROL, IDX_CAPTURE_RELOAD_LOW,
      IDX_CAPTURE_RELOAD_HIGH, IDX_CLOCK_CONTROL, IDX_COUNT_READBACK, 8'h10};
    foreach (ix[i]) begin
      bus(0, ix[i], 8'h00);
      chk("reset read", rd, 32'h0);
    end
    chk("hresp", hresp, 1'b0);
  endtask : s_reset
  task automatic s_reload();
    bus(1, IDX_TIMER_CONTROL, 8'h06);
    repeat (5) fall(0);
    bus(0, IDX_COUNT_READBACK, 8'h00);
    chk("pin count", rd, 32'h5);
    fall(1);
    bus(0, IDX_TIMER_CONTROL, 8'h00);
    chk("trigger ignored", rd, 32'h06);
    bus(1, IDX_CAPTURE_RELOAD_LOW, 8'hF0);
    bus(1, IDX_CAPTURE_RELOAD_HIGH, 8'hFF);
    bus(1, IDX_TIMER_CONTROL, 8'h0E);
    fall(1);
    bus(0, IDX_COUNT_READBACK, 8'h00);
    chk("trigger reload", rd, 32'hFFF0);
    bus(0, IDX_TIMER_CONTROL, 8'h00);
    chk("edge flag", rd, 32'h4E);
    chk("irq set", irq, 1'b1);
    bus(1, IDX_TIMER_CONTROL, 8'h06);
    @(posedge clk);
    chk("irq clear", irq, 1'b0);
    bus(1, IDX_CLOCK_CONTROL, 8'h01);
    bus(1, IDX_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    bus(0, IDX_TIMER_CONTROL, 8'h00);
    chk("overflow flag", rd, 32'h84);
    bus(0, IDX_COUNT_READBACK, 8'h00);
    chk("reloaded", rd[15:4], 12'hFFF);
    bus(1, IDX_TIMER_CONTROL, 8'h00);
    bus(0, IDX_COUNT_READBACK, 8'h00);
    p = rd;
    repeat (20) @(posedge clk);
    bus(0, IDX_COUNT_READBACK, 8'h00);
    chk("stopped", rd, p);
  endtask : s_reload
  task automatic s_capture();
    bus(1, IDX_TIMER_CONTROL, 8'h0B);
    fall(1);
    bus(0, IDX_TIMER_CONTROL, 8'h00);
    chk("no capture", rd[6], 1'b0);
    bus(1, IDX_TIMER_CONTROL, 8'h0F);
    fall(1);
    bus(0, IDX_CAPTURE_RELOAD_LOW, 8'h00);
    p = rd;
    bus(0, IDX_CAPTURE_RELOAD_HIGH, 8'h00);
    p = {16'h0, rd[7:0], p[7:0]};
    bus(0, IDX_COUNT_READBACK, 8'h00);
    chk("capture pair", rd, p);
    bus(1, IDX_TIMER_CONTROL, 8'h0F);
    repeat (3) fall(0);
    fall(1);
    bus(0, IDX_CAPTURE_RELOAD_LOW, 8'h00);
    chk("capture low", rd, {24'h0, 8'(p + 3)});
    bus(0, IDX_CAPTURE_RELOAD_HIGH, 8'h00);
    chk("capture high", rd, {24'h0, 8'((p + 3) >> 8)});
    bus(0, IDX_TIMER_CONTROL, 8'h00);
    chk("capture flag", rd[6], 1'b1);
  endtask : s_capture
  task automatic s_baud();
    bus(1, IDX_CAPTURE_RELOAD_LOW, 8'hFE);
    bus(1, IDX_CAPTURE_RELOAD_HIGH, 8'hFF);
    bus(1, IDX_TIMER_CONTROL, 8'h0E);
    fall(1);
    bus(1, IDX_TIMER_CONTROL, 8'h3C);
    r0 = rxn;
    t0 = txn;
    repeat (400) @(posedge clk);
    chk("rx ticks", 32'((rxn - r0) inside {[99:101]}), 1);
    chk("tx ticks", 32'((txn - t0) inside {[99:101]}), 1);
    fall(1);
    bus(0, IDX_TIMER_CONTROL, 8'h00);
    chk("baud flags", rd, 32'h7C);
    bus(0, IDX_CAPTURE_RELOAD_LOW, 8'h00);
    chk("no capture", rd, 32'hFE);
    bus(1, IDX_TIMER_CONTROL, 8'h24);
    t0 = txn;
    repeat (70) @(posedge clk);
    chk("tx timer1", 32'((txn - t0) inside {[9:11]}), 1);
    bus(1, IDX_TIMER_CONTROL, 8'h26);
    repeat (4) @(posedge clk);
    r0 = rxn;
    repeat (4) fall(0);
    chk("pin baud", rxn - r0, 2);
  endtask : s_baud
  task automatic s_slow();
    bus(1, IDX_CAPTURE_RELOAD_LOW, 8'h00);
    bus(1, IDX_CAPTURE_RELOAD_HIGH, 8'h00);
    bus(1, IDX_CLOCK_CONTROL, 8'h00);
    bus(1, IDX_TIMER_CONTROL, 8'h0E);
    fall(1);
    bus(1, IDX_TIMER_CONTROL, 8'h04);
    repeat (120) @(posedge clk);
    bus(1, IDX_TIMER_CONTROL, 8'h00);
    bus(0, IDX_COUNT_READBACK, 8'h00);
    chk("divided steps", 32'(rd inside {[10:11]}), 1);
  endtask : s_slow
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    s_reset();
    s_reload();
    s_capture();
    s_baud();
    s_slow();
    print_verdict();
  end
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end
endmodule : capture_reload_baud_timer_test

// ==== sim/crb_uart_model.sv ====
// second serial port model: counts shift ticks, makes timer 1 overflows
`timescale 1ns/1ps
module crb_uart_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_tick_i,
  input wire logic tx_tick_i,
  output logic t1_ovf_o,
  output int rx_cnt_o,
  output int tx_cnt_o
);
  int div;
  // timer 1 overflow is a one-cycle pulse every 7 clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 0;
      t1_ovf_o <= 1'b0;
      rx_cnt_o <= 0;
      tx_cnt_o <= 0;
    end else begin
      div <= (div == 6) ? 0 : div + 1;
      t1_ovf_o <= (div == 6);
      rx_cnt_o <= rx_cnt_o + int'(rx_tick_i);
      tx_cnt_o <= tx_cnt_o + int'(tx_tick_i);
    end
  end
endmodule : crb_uart_model
